//--- rtl/iors_pkg.sv
package iors_pkg;

  // Reset value of every stored register
  localparam logic [7:0] RST_VAL = 8'h00;

  // Address views and ranges
  localparam logic [7:0] DATA_OFS  = 8'h20;  // I/O index to data address
  localparam logic [7:0] BIT_TOP   = 8'h1f;  // Last bit-accessible I/O index
  localparam logic [7:0] SHORT_TOP = 8'h3f;  // Last short I/O index
  localparam logic [7:0] EXT_BASE  = 8'h60;  // First extended data address
  localparam logic [5:0] OWN_TOP   = 6'h2a;  // Last index decoded here

  // Port register offsets
  localparam logic [5:0] PORT_A_PIN_INPUT = 6'h00, PORT_A_DIRECTION = 6'h01, PORT_A_OUTPUT = 6'h02;
  localparam logic [5:0] PORT_B_PIN_INPUT = 6'h03, PORT_B_DIRECTION = 6'h04, PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] PORT_C_PIN_INPUT = 6'h06, PORT_C_DIRECTION = 6'h07, PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] PORT_D_PIN_INPUT = 6'h09, PORT_D_DIRECTION = 6'h0a, PORT_D_OUTPUT = 6'h0b;
  localparam logic [5:0] PORT_E_PIN_INPUT = 6'h0c, PORT_E_DIRECTION = 6'h0d, PORT_E_OUTPUT = 6'h0e;
  localparam logic [5:0] PORT_F_PIN_INPUT = 6'h0f, PORT_F_DIRECTION = 6'h10, PORT_F_OUTPUT = 6'h11;
  localparam logic [5:0] PORT_G_PIN_INPUT = 6'h12, PORT_G_DIRECTION = 6'h13, PORT_G_OUTPUT = 6'h14;

  // Flag, mask, scratch, nonvolatile memory and timer offsets
  localparam logic [5:0] TIMER0_FLAGS = 6'h15, TIMER1_FLAGS = 6'h16, TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] TIMER3_FLAGS = 6'h18, EXT_IRQ_FLAGS = 6'h1c, EXT_IRQ_MASK = 6'h1d;
  localparam logic [5:0] GENERAL_SCRATCH_0 = 6'h1e, GENERAL_SCRATCH_1 = 6'h2a;
  localparam logic [5:0] NVM_CONTROL = 6'h1f, NVM_DATA = 6'h20;
  localparam logic [5:0] NVM_ADDRESS_LOW = 6'h21, NVM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] TIMER_GENERAL_CONTROL = 6'h23, TIMER0_CONTROL = 6'h24;
  localparam logic [5:0] TIMER0_COUNT = 6'h26, TIMER0_COMPARE = 6'h27;

  // Implemented bit masks
  localparam logic [7:0] PORT_FULL_VALID  = 8'hff;
  localparam logic [7:0] PORT_G_VALID     = 8'h1f;
  localparam logic [7:0] TIMER0_FLG_VALID = 8'h03, TIMER1_FLG_VALID = 8'h2f;
  localparam logic [7:0] TIMER2_FLG_VALID = 8'h03, TIMER3_FLG_VALID = 8'h2f;
  localparam logic [7:0] EXT_FLG_VALID    = 8'hff;
  localparam logic [7:0] NVM_CTL_VALID    = 8'h0f;
  localparam logic [7:0] GEN_CTL_VALID    = 8'h83;
  localparam logic [7:0] T0_CTL_STORED    = 8'h7f;  // Top bit is a force strobe
  localparam int         T0_FORCE_BIT     = 7;
  localparam int         NVM_TOP_DEFAULT  = 11;

  // Per-port and per-flag tables
  localparam int NUM_PORTS = 7;
  localparam int NUM_FLAGS = 5;
  localparam logic [5:0] PORT_PIN_OFS [NUM_PORTS] = '{PORT_A_PIN_INPUT, PORT_B_PIN_INPUT,
    PORT_C_PIN_INPUT, PORT_D_PIN_INPUT, PORT_E_PIN_INPUT, PORT_F_PIN_INPUT, PORT_G_PIN_INPUT};
  localparam logic [5:0] PORT_DIR_OFS [NUM_PORTS] = '{PORT_A_DIRECTION, PORT_B_DIRECTION,
    PORT_C_DIRECTION, PORT_D_DIRECTION, PORT_E_DIRECTION, PORT_F_DIRECTION, PORT_G_DIRECTION};
  localparam logic [5:0] PORT_OUT_OFS [NUM_PORTS] = '{PORT_A_OUTPUT, PORT_B_OUTPUT,
    PORT_C_OUTPUT, PORT_D_OUTPUT, PORT_E_OUTPUT, PORT_F_OUTPUT, PORT_G_OUTPUT};
  localparam logic [7:0] PORT_VALID [NUM_PORTS] = '{PORT_FULL_VALID, PORT_FULL_VALID,
    PORT_FULL_VALID, PORT_FULL_VALID, PORT_FULL_VALID, PORT_FULL_VALID, PORT_G_VALID};
  localparam logic [5:0] FLAG_OFS [NUM_FLAGS] = '{TIMER0_FLAGS, TIMER1_FLAGS,
    TIMER2_FLAGS, TIMER3_FLAGS, EXT_IRQ_FLAGS};
  localparam logic [7:0] FLAG_VALID [NUM_FLAGS] = '{TIMER0_FLG_VALID, TIMER1_FLG_VALID,
    TIMER2_FLG_VALID, TIMER3_FLG_VALID, EXT_FLG_VALID};

  // Core access kinds
  typedef enum logic [2:0] {
    OP_IN_INSTR,
    OP_OUT_INSTR,
    OP_LOAD_INSTR,
    OP_STORE_INSTR,
    OP_SET_BIT_INSTR,
    OP_CLEAR_BIT_INSTR,
    OP_SKIP_IF_BIT_SET_INSTR,
    OP_SKIP_IF_BIT_CLEAR_INSTR
  } iors_op_t;

endpackage

//--- rtl/iors_port.sv
`timescale 1ns/10ps
// One I/O port: sampled pins, direction and output latches
module iors_port #(
  parameter logic [5:0] DIR_OFS = 6'h01,
  parameter logic [5:0] OUT_OFS = 6'h02,
  parameter logic [7:0] VALID   = 8'hff
) (
  input  wire logic       clk,      // Core clock
  input  wire logic       sys_rst,  // Synchronous reset
  input  wire logic       wr_en,    // Decoded write strobe
  input  wire logic [5:0] wr_idx,   // I/O index
  input  wire logic [7:0] wr_mask,  // Bits to change
  input  wire logic [7:0] wr_data,  // Write data
  input  wire logic [7:0] pin_in,   // Pin levels
  output logic      [7:0] pin_q,    // Sampled pins
  output logic      [7:0] dir_q,    // Direction latch
  output logic      [7:0] out_q     // Output latch
);

  // Pins sampled each cycle, missing bits read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_q <= iors_pkg::RST_VAL;
    end else begin
      pin_q <= pin_in & VALID;
    end
  end

  // Only the bits in the mask change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_q <= iors_pkg::RST_VAL;
      out_q <= iors_pkg::RST_VAL;
    end else if (wr_en) begin
      if (wr_idx == DIR_OFS) begin
        dir_q <= ((dir_q & ~wr_mask) | (wr_data & wr_mask)) & VALID;
      end
      if (wr_idx == OUT_OFS) begin
        out_q <= ((out_q & ~wr_mask) | (wr_data & wr_mask)) & VALID;
      end
    end
  end

endmodule

//--- rtl/iors_decode.sv
`timescale 1ns/10ps
// How it works
// - Nonvolatile address bits above top bit ignored
// - Bit set/clear only for indices 0x00-0x1F
// - Bit test-and-skip on bit-accessible indices
// - Status flags clear on written one
// - Bit set/clear touches only addressed bit
// - Short transfers use indices 0x00-0x3F
// - Data view adds 0x20 to index
// - Extended space reached by load/store only
module iors_decode #(
  parameter int NVM_ADDR_TOP_BIT = iors_pkg::NVM_TOP_DEFAULT
) (
  input  wire logic              clk,                  // Core clock
  input  wire logic              sys_rst,              // Synchronous reset
  input  wire logic              req_valid,            // Access request
  input  iors_pkg::iors_op_t     req_op,               // Access kind
  input  wire logic        [7:0] req_addr,             // I/O index or data address
  input  wire logic        [2:0] req_bit,              // Bit for bit operations
  input  wire logic        [7:0] req_wdata,            // Write data
  output logic                   ack_q,                // Answer strobe
  output logic                   err_q,                // Address out of range
  output logic             [7:0] rdata_q,              // Read data
  output logic                   skip_q,               // Skip next instruction
  output logic                   ext_sel,              // Forwarded access
  output logic                   ext_we,               // Forwarded write
  output logic             [7:0] ext_addr,             // Forwarded data address
  output logic             [7:0] ext_wdata,            // Forwarded write data
  input  wire logic        [7:0] ext_rdata,            // Forwarded read data
  input  wire logic        [7:0] pin_a,                // Port A pins
  input  wire logic        [7:0] pin_b,                // Port B pins
  input  wire logic        [7:0] pin_c,                // Port C pins
  input  wire logic        [7:0] pin_d,                // Port D pins
  input  wire logic        [7:0] pin_e,                // Port E pins
  input  wire logic        [7:0] pin_f,                // Port F pins
  input  wire logic        [7:0] pin_g,                // Port G pins
  output logic             [7:0] dir_a,                // Port A direction
  output logic             [7:0] dir_b,                // Port B direction
  output logic             [7:0] dir_c,                // Port C direction
  output logic             [7:0] dir_d,                // Port D direction
  output logic             [7:0] dir_e,                // Port E direction
  output logic             [7:0] dir_f,                // Port F direction
  output logic             [7:0] dir_g,                // Port G direction
  output logic             [7:0] out_a,                // Port A output
  output logic             [7:0] out_b,                // Port B output
  output logic             [7:0] out_c,                // Port C output
  output logic             [7:0] out_d,                // Port D output
  output logic             [7:0] out_e,                // Port E output
  output logic             [7:0] out_f,                // Port F output
  output logic             [7:0] out_g,                // Port G output
  input  wire logic        [7:0] timer0_flag_set,      // Timer 0 events
  input  wire logic        [7:0] timer1_flag_set,      // Timer 1 events
  input  wire logic        [7:0] timer2_flag_set,      // Timer 2 events
  input  wire logic        [7:0] timer3_flag_set,      // Timer 3 events
  input  wire logic        [7:0] ext_irq_set,          // External interrupt events
  output logic             [7:0] timer0_flags_q,       // Timer 0 flags
  output logic             [7:0] timer1_flags_q,       // Timer 1 flags
  output logic             [7:0] timer2_flags_q,       // Timer 2 flags
  output logic             [7:0] timer3_flags_q,       // Timer 3 flags
  output logic             [7:0] ext_irq_flags_q,      // External interrupt flags
  output logic             [7:0] ext_irq_mask_q,       // External interrupt mask
  output logic             [7:0] nvm_control_q,        // Nonvolatile control
  output logic             [7:0] nvm_data_q,           // Nonvolatile data
  output logic            [15:0] nvm_addr_q,           // Nonvolatile address
  output logic             [7:0] timer_general_q,      // Timer general control
  output logic             [7:0] timer0_control_q,     // Timer 0 control
  output logic                   timer0_force_q,       // Timer 0 force pulse
  output logic             [7:0] timer0_count_q,       // Timer 0 count
  output logic             [7:0] timer0_compare_q      // Timer 0 compare
);

  localparam int NP = iors_pkg::NUM_PORTS;
  localparam int NF = iors_pkg::NUM_FLAGS;
  localparam logic [15:0] NVM_MASK = 16'((32'h1 << (NVM_ADDR_TOP_BIT + 1)) - 32'h1);

  logic       is_short;
  logic       is_bitop;
  logic       is_write;
  logic       is_read;
  logic       range_err;
  logic       to_ext;
  logic       own_hit;
  logic       wr_en;
  logic [5:0] idx;
  logic [7:0] wr_mask;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic       rd_bit;
  logic [7:0] scratch0_q;
  logic [7:0] scratch1_q;
  logic [7:0] pin_arr [NP];
  logic [7:0] pin_q   [NP];
  logic [7:0] dir_arr [NP];
  logic [7:0] out_arr [NP];
  logic [7:0] fset    [NF];
  logic [7:0] flag_q  [NF];

  // Kind of access
  always_comb begin
    is_bitop = req_op inside {iors_pkg::OP_SET_BIT_INSTR, iors_pkg::OP_CLEAR_BIT_INSTR,
                              iors_pkg::OP_SKIP_IF_BIT_SET_INSTR, iors_pkg::OP_SKIP_IF_BIT_CLEAR_INSTR};
    is_short = is_bitop || req_op inside {iors_pkg::OP_IN_INSTR, iors_pkg::OP_OUT_INSTR};
    is_write = req_op inside {iors_pkg::OP_OUT_INSTR, iors_pkg::OP_STORE_INSTR,
                              iors_pkg::OP_SET_BIT_INSTR, iors_pkg::OP_CLEAR_BIT_INSTR};
    is_read  = req_op inside {iors_pkg::OP_IN_INSTR, iors_pkg::OP_LOAD_INSTR};
  end

  // Address views mapped onto one I/O index
  always_comb begin
    range_err = 1'b0;
    to_ext    = 1'b0;
    idx       = req_addr[5:0];
    if (is_short) begin
      if (req_addr > iors_pkg::SHORT_TOP) begin
        range_err = 1'b1;
      end else if (is_bitop && req_addr > iors_pkg::BIT_TOP) begin
        range_err = 1'b1;
      end
    end else if (req_addr < iors_pkg::DATA_OFS) begin
      range_err = 1'b1;
    end else if (req_addr >= iors_pkg::EXT_BASE) begin
      to_ext = 1'b1;
    end else begin
      idx = 6'(req_addr - iors_pkg::DATA_OFS);
    end
    if (!range_err && idx > iors_pkg::OWN_TOP) begin
      to_ext = 1'b1;
    end
  end

  // Write shaping: bit operations carry a one-hot mask
  always_comb begin
    wr_mask = is_bitop ? (8'h01 << req_bit) : 8'hff;
    case (req_op)
      iors_pkg::OP_SET_BIT_INSTR:   wr_data = 8'hff;
      iors_pkg::OP_CLEAR_BIT_INSTR: wr_data = 8'h00;
      default:                      wr_data = req_wdata;
    endcase
  end

  assign own_hit   = req_valid && !range_err && !to_ext;
  assign wr_en     = own_hit && is_write;
  assign ext_sel   = req_valid && !range_err && to_ext;
  assign ext_we    = ext_sel && is_write;
  assign ext_wdata = req_wdata;
  // Forwarded address is always in data-space form
  assign ext_addr  = is_short ? 8'({2'b00, idx} + iors_pkg::DATA_OFS) : req_addr;

  // Ports
  assign pin_arr = '{pin_a, pin_b, pin_c, pin_d, pin_e, pin_f, pin_g};
  assign {dir_a, dir_b, dir_c, dir_d, dir_e, dir_f, dir_g} =
         {dir_arr[0], dir_arr[1], dir_arr[2], dir_arr[3], dir_arr[4], dir_arr[5], dir_arr[6]};
  assign {out_a, out_b, out_c, out_d, out_e, out_f, out_g} =
         {out_arr[0], out_arr[1], out_arr[2], out_arr[3], out_arr[4], out_arr[5], out_arr[6]};

  for (genvar p = 0; p < NP; p++) begin : g_port
    iors_port #(
      .DIR_OFS (iors_pkg::PORT_DIR_OFS[p]),
      .OUT_OFS (iors_pkg::PORT_OUT_OFS[p]),
      .VALID   (iors_pkg::PORT_VALID[p])
    ) u_port (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_en),
      .wr_idx  (idx),
      .wr_mask (wr_mask),
      .wr_data (wr_data),
      .pin_in  (pin_arr[p]),
      .pin_q   (pin_q[p]),
      .dir_q   (dir_arr[p]),
      .out_q   (out_arr[p])
    );
  end

  // Status flags: event sets win over a write-one clear
  assign fset = '{timer0_flag_set, timer1_flag_set, timer2_flag_set, timer3_flag_set, ext_irq_set};
  assign {timer0_flags_q, timer1_flags_q, timer2_flags_q, timer3_flags_q, ext_irq_flags_q} =
         {flag_q[0], flag_q[1], flag_q[2], flag_q[3], flag_q[4]};

  for (genvar f = 0; f < NF; f++) begin : g_flag
    logic [7:0] clr;
    assign clr = (wr_en && idx == iors_pkg::FLAG_OFS[f]) ? (wr_mask & wr_data) : 8'h00;
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        flag_q[f] <= iors_pkg::RST_VAL;
      end else begin
        flag_q[f] <= ((flag_q[f] & ~clr) | fset[f]) & iors_pkg::FLAG_VALID[f];
      end
    end
  end

  // Mask and scratch registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_irq_mask_q <= iors_pkg::RST_VAL;
      scratch0_q     <= iors_pkg::RST_VAL;
      scratch1_q     <= iors_pkg::RST_VAL;
    end else if (wr_en) begin
      case (idx)
        iors_pkg::EXT_IRQ_MASK:      ext_irq_mask_q <= (ext_irq_mask_q & ~wr_mask) | (wr_data & wr_mask);
        iors_pkg::GENERAL_SCRATCH_0: scratch0_q <= (scratch0_q & ~wr_mask) | (wr_data & wr_mask);
        iors_pkg::GENERAL_SCRATCH_1: scratch1_q <= wr_data;
        default: ;
      endcase
    end
  end

  // Nonvolatile memory access registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nvm_control_q <= iors_pkg::RST_VAL;
      nvm_data_q    <= iors_pkg::RST_VAL;
      nvm_addr_q    <= {iors_pkg::RST_VAL, iors_pkg::RST_VAL};
    end else if (wr_en) begin
      case (idx)
        iors_pkg::NVM_CONTROL:
          nvm_control_q <= ((nvm_control_q & ~wr_mask) | (wr_data & wr_mask)) & iors_pkg::NVM_CTL_VALID;
        iors_pkg::NVM_DATA:         nvm_data_q <= wr_data;
        iors_pkg::NVM_ADDRESS_LOW:  nvm_addr_q[7:0] <= wr_data & NVM_MASK[7:0];
        iors_pkg::NVM_ADDRESS_HIGH: nvm_addr_q[15:8] <= wr_data & NVM_MASK[15:8];
        default: ;
      endcase
    end
  end

  // Timer control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_general_q  <= iors_pkg::RST_VAL;
      timer0_control_q <= iors_pkg::RST_VAL;
      timer0_count_q   <= iors_pkg::RST_VAL;
      timer0_compare_q <= iors_pkg::RST_VAL;
    end else if (wr_en) begin
      case (idx)
        iors_pkg::TIMER_GENERAL_CONTROL: timer_general_q <= wr_data & iors_pkg::GEN_CTL_VALID;
        iors_pkg::TIMER0_CONTROL:        timer0_control_q <= wr_data & iors_pkg::T0_CTL_STORED;
        iors_pkg::TIMER0_COUNT:          timer0_count_q <= wr_data;
        iors_pkg::TIMER0_COMPARE:        timer0_compare_q <= wr_data;
        default: ;
      endcase
    end
  end

  // Force strobe: one cycle, never stored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer0_force_q <= 1'b0;
    end else begin
      timer0_force_q <= wr_en && idx == iors_pkg::TIMER0_CONTROL && wr_data[iors_pkg::T0_FORCE_BIT];
    end
  end

  // Read multiplexer; anything not decoded reads zero
  always_comb begin
    rd_byte = 8'h00;
    for (int p = 0; p < NP; p++) begin
      if (idx == iors_pkg::PORT_PIN_OFS[p]) rd_byte = pin_q[p];
      if (idx == iors_pkg::PORT_DIR_OFS[p]) rd_byte = dir_arr[p];
      if (idx == iors_pkg::PORT_OUT_OFS[p]) rd_byte = out_arr[p];
    end
    for (int f = 0; f < NF; f++) begin
      if (idx == iors_pkg::FLAG_OFS[f]) rd_byte = flag_q[f];
    end
    case (idx)
      iors_pkg::EXT_IRQ_MASK:          rd_byte = ext_irq_mask_q;
      iors_pkg::GENERAL_SCRATCH_0:     rd_byte = scratch0_q;
      iors_pkg::GENERAL_SCRATCH_1:     rd_byte = scratch1_q;
      iors_pkg::NVM_CONTROL:           rd_byte = nvm_control_q;
      iors_pkg::NVM_DATA:              rd_byte = nvm_data_q;
      iors_pkg::NVM_ADDRESS_LOW:       rd_byte = nvm_addr_q[7:0];
      iors_pkg::NVM_ADDRESS_HIGH:      rd_byte = nvm_addr_q[15:8];
      iors_pkg::TIMER_GENERAL_CONTROL: rd_byte = timer_general_q;
      iors_pkg::TIMER0_CONTROL:        rd_byte = timer0_control_q;
      iors_pkg::TIMER0_COUNT:          rd_byte = timer0_count_q;
      iors_pkg::TIMER0_COMPARE:        rd_byte = timer0_compare_q;
      default: ;
    endcase
  end

  assign rd_bit = rd_byte[req_bit];

  // Answer one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 8'h00;
      skip_q  <= 1'b0;
    end else begin
      ack_q   <= req_valid;
      err_q   <= req_valid && range_err;
      rdata_q <= 8'h00;
      skip_q  <= 1'b0;
      if (ext_sel && is_read) begin
        rdata_q <= ext_rdata;
      end else if (own_hit && is_read) begin
        rdata_q <= rd_byte;
      end
      if (own_hit && req_op == iors_pkg::OP_SKIP_IF_BIT_SET_INSTR) begin
        skip_q <= rd_bit;
      end else if (own_hit && req_op == iors_pkg::OP_SKIP_IF_BIT_CLEAR_INSTR) begin
        skip_q <= !rd_bit;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_bit_out_of_range;
    req_valid && is_bitop && req_addr > iors_pkg::BIT_TOP && req_addr <= iors_pkg::SHORT_TOP;
  endsequence
  sequence s_set_dir_a;
    req_valid && req_op == iors_pkg::OP_SET_BIT_INSTR && req_addr == {2'b00, iors_pkg::PORT_A_DIRECTION};
  endsequence
  sequence s_t0_flag_write;
    req_valid && req_op == iors_pkg::OP_OUT_INSTR && req_addr == {2'b00, iors_pkg::TIMER0_FLAGS};
  endsequence

  a_nvm_top_ignored: assert property ((nvm_addr_q & ~NVM_MASK) == 16'h0000)
    else $error("nvm address holds bits above top bit");
  a_bitop_range: assert property (s_bit_out_of_range |-> !ext_sel ##1 (err_q && !skip_q))
    else $error("bit operation above bit range accepted");
  a_set_bit_only: assert property (s_set_dir_a |=> dir_a == ($past(dir_a) | (8'h01 << $past(req_bit))))
    else $error("bit set changed other bits");
  a_bitop_flag_keep: assert property (
    req_valid && req_op == iors_pkg::OP_SET_BIT_INSTR && req_addr == {2'b00, iors_pkg::EXT_IRQ_FLAGS}
    |=> ext_irq_flags_q == (($past(ext_irq_flags_q) & ~(8'h01 << $past(req_bit))) | $past(ext_irq_set)))
    else $error("bit set on flags cleared other flags");
  a_skip_follows_bit: assert property (own_hit && req_op == iors_pkg::OP_SKIP_IF_BIT_CLEAR_INSTR
    |=> ack_q && skip_q == !$past(rd_bit))
    else $error("skip result wrong");
  a_w1c_one_clears: assert property ((s_t0_flag_write and (req_wdata[0] && !timer0_flag_set[0]))
    |=> !timer0_flags_q[0])
    else $error("flag not cleared by one");
  a_w1c_zero_keeps: assert property ((s_t0_flag_write and (req_wdata == 8'h00))
    |=> timer0_flags_q == (($past(timer0_flags_q) | $past(timer0_flag_set)) & iors_pkg::TIMER0_FLG_VALID))
    else $error("flag changed by zero write");
  a_short_range: assert property (req_valid && is_short && req_addr > iors_pkg::SHORT_TOP
    |-> !ext_sel ##1 (err_q && rdata_q == 8'h00))
    else $error("short access above range accepted");
  a_data_offset: assert property (req_valid && req_op == iors_pkg::OP_STORE_INSTR
    && req_addr == 8'({2'b00, iors_pkg::PORT_A_OUTPUT} + iors_pkg::DATA_OFS) |=> out_a == $past(req_wdata))
    else $error("data view offset wrong");
  a_ext_data_only: assert property (ext_sel && ext_addr >= iors_pkg::EXT_BASE
    |-> req_op inside {iors_pkg::OP_LOAD_INSTR, iors_pkg::OP_STORE_INSTR})
    else $error("extended space reached by short access");
  a_reserved_zero: assert property (req_valid && req_op == iors_pkg::OP_IN_INSTR && req_addr == 8'h19
    |=> ack_q && !err_q && rdata_q == 8'h00)
    else $error("reserved location read nonzero");

endmodule

//--- sim/iors_ext_mem.sv
`timescale 1ns/10ps
// Far-side store behind forwarded data addresses
module iors_ext_mem (
  input  wire logic       clk,    // Core clock
  input  wire logic       sel,    // Access select
  input  wire logic       we,     // Write enable
  input  wire logic [7:0] addr,   // Data address
  input  wire logic [7:0] wdata,  // Write data
  output logic      [7:0] rdata   // Read data, same cycle
);
  logic [7:0] mem_q [256];
  // Unselected, the bus shows a pattern that follows the address
  assign rdata = sel ? mem_q[addr] : ~addr;
  // Writes land on the taking edge
  always_ff @(posedge clk) begin
    if (sel && we) begin
      mem_q[addr] <= wdata;
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the I/O register decode
module testbench;
  typedef struct {iors_pkg::iors_op_t op; logic [7:0] a; logic [2:0] b; logic [7:0] w, r; logic [1:0] es;} iors_row_t;
  logic clk, sys_rst, req_valid, ack_q, err_q, skip_q, ext_sel, ext_we, force_q;
  iors_pkg::iors_op_t req_op;
  logic [7:0] req_addr, req_wdata, rdata_q, ext_addr, ext_wdata, ext_rdata, pins, fset, out_a;
  logic [2:0] req_bit;
  int miscompares, samples_checked;
  iors_decode #(.NVM_ADDR_TOP_BIT(9)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_bit(req_bit),
    .req_wdata(req_wdata), .ack_q(ack_q), .err_q(err_q), .rdata_q(rdata_q), .skip_q(skip_q), .ext_sel(ext_sel),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .pin_a(pins), .pin_b(pins),
    .pin_c(pins), .pin_d(pins), .pin_e(pins), .pin_f(pins), .pin_g(pins), .dir_a(), .dir_b(), .dir_c(), .dir_d(),
    .dir_e(), .dir_f(), .dir_g(), .out_a(out_a), .out_b(), .out_c(), .out_d(), .out_e(), .out_f(), .out_g(),
    .timer0_flag_set(fset), .timer1_flag_set(fset), .timer2_flag_set(fset), .timer3_flag_set(fset),
    .ext_irq_set(fset), .timer0_flags_q(), .timer1_flags_q(), .timer2_flags_q(), .timer3_flags_q(),
    .ext_irq_flags_q(), .ext_irq_mask_q(), .nvm_control_q(), .nvm_data_q(), .nvm_addr_q(), .timer_general_q(),
    .timer0_control_q(), .timer0_force_q(force_q), .timer0_count_q(), .timer0_compare_q());
  iors_ext_mem u_ext (.clk(clk), .sel(ext_sel), .we(ext_we), .addr(ext_addr), .wdata(ext_wdata), .rdata(ext_rdata));
  // Ordinary accesses, issued back to back
  iors_row_t rows [20] = '{
    '{iors_pkg::OP_OUT_INSTR, 8'h02, 3'h0, 8'h5a, 8'h00, 2'h0}, '{iors_pkg::OP_IN_INSTR, 8'h02, 3'h0, 8'h00, 8'h5a, 2'h0},
    '{iors_pkg::OP_LOAD_INSTR, 8'h22, 3'h0, 8'h00, 8'h5a, 2'h0},
    '{iors_pkg::OP_STORE_INSTR, 8'h41, 3'h0, 8'ha5, 8'h00, 2'h0}, '{iors_pkg::OP_IN_INSTR, 8'h21, 3'h0, 8'h00, 8'ha5, 2'h0},
    '{iors_pkg::OP_SET_BIT_INSTR, 8'h01, 3'h3, 8'h00, 8'h00, 2'h0}, '{iors_pkg::OP_IN_INSTR, 8'h01, 3'h0, 8'h00, 8'h08, 2'h0},
    '{iors_pkg::OP_CLEAR_BIT_INSTR, 8'h02, 3'h4, 8'h00, 8'h00, 2'h0}, '{iors_pkg::OP_IN_INSTR, 8'h02, 3'h0, 8'h00, 8'h4a, 2'h0},
    '{iors_pkg::OP_SKIP_IF_BIT_SET_INSTR, 8'h02, 3'h1, 8'h00, 8'h00, 2'h1},
    '{iors_pkg::OP_SKIP_IF_BIT_CLEAR_INSTR, 8'h02, 3'h0, 8'h00, 8'h00, 2'h1},
    '{iors_pkg::OP_SKIP_IF_BIT_SET_INSTR, 8'h02, 3'h0, 8'h00, 8'h00, 2'h0},
    '{iors_pkg::OP_SET_BIT_INSTR, 8'h20, 3'h0, 8'h00, 8'h00, 2'h2},
    '{iors_pkg::OP_IN_INSTR, 8'h40, 3'h0, 8'h00, 8'h00, 2'h2},
    '{iors_pkg::OP_LOAD_INSTR, 8'h1f, 3'h0, 8'h00, 8'h00, 2'h2},
    '{iors_pkg::OP_STORE_INSTR, 8'h80, 3'h0, 8'hc3, 8'h00, 2'h0}, '{iors_pkg::OP_LOAD_INSTR, 8'h80, 3'h0, 8'h00, 8'hc3, 2'h0},
    '{iors_pkg::OP_IN_INSTR, 8'h19, 3'h0, 8'h00, 8'h00, 2'h0},
    '{iors_pkg::OP_OUT_INSTR, 8'h22, 3'h0, 8'h0f, 8'h00, 2'h0}, '{iors_pkg::OP_IN_INSTR, 8'h22, 3'h0, 8'h00, 8'h03, 2'h0}};
  // Clock
  always #2 clk = ~clk;
  // One access: present at a falling edge, judge the answer one cycle on
  task automatic acc(input iors_row_t t);
    {req_valid, req_op, req_addr, req_bit, req_wdata} = {1'b1, t.op, t.a, t.b, t.w};
    @(negedge clk);
    samples_checked++;
    if ({ack_q, err_q, skip_q, rdata_q} !== {1'b1, t.es, t.r}) begin
      miscompares++;
      $display("MISMATCH %0t addr %h got %b%b%b %h", $time, t.a, ack_q, err_q, skip_q, rdata_q);
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    {clk, sys_rst, req_valid, req_addr, req_bit, req_wdata, pins, fset} = {2'b01, 36'h0};
    req_op = iors_pkg::OP_IN_INSTR;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i]);
    end
    req_valid = 1'b0;
    $display("Row tests done");
    fset = 8'h03;
    pins = 8'h5c;
    @(negedge clk);
    fset = 8'h00;
    acc('{iors_pkg::OP_SET_BIT_INSTR, 8'h15, 3'h0, 8'h00, 8'h00, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h15, 3'h0, 8'h00, 8'h02, 2'h0});
    acc('{iors_pkg::OP_OUT_INSTR, 8'h15, 3'h0, 8'h00, 8'h00, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h15, 3'h0, 8'h00, 8'h02, 2'h0});
    acc('{iors_pkg::OP_OUT_INSTR, 8'h15, 3'h0, 8'h03, 8'h00, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h15, 3'h0, 8'h00, 8'h00, 2'h0});
    acc('{iors_pkg::OP_SET_BIT_INSTR, 8'h1c, 3'h1, 8'h00, 8'h00, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h1c, 3'h0, 8'h00, 8'h01, 2'h0});
    // Event and write-one clear in the same cycle: the event wins
    fset = 8'h01;
    acc('{iors_pkg::OP_OUT_INSTR, 8'h15, 3'h0, 8'h01, 8'h00, 2'h0});
    fset = 8'h00;
    acc('{iors_pkg::OP_IN_INSTR, 8'h15, 3'h0, 8'h00, 8'h01, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h12, 3'h0, 8'h00, 8'h1c, 2'h0});
    acc('{iors_pkg::OP_STORE_INSTR, 8'h22, 3'h0, 8'h3c, 8'h00, 2'h0});
    acc('{iors_pkg::OP_IN_INSTR, 8'h02, 3'h0, 8'h00, 8'h3c, 2'h0});
    // Force bit pulses once and is never stored
    acc('{iors_pkg::OP_OUT_INSTR, 8'h24, 3'h0, 8'h81, 8'h00, 2'h0});
    samples_checked++;
    if (force_q !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t force pulse missing", $time);
    end
    acc('{iors_pkg::OP_IN_INSTR, 8'h24, 3'h0, 8'h00, 8'h01, 2'h0});
    req_valid = 1'b0;
    $display("Flag tests done");
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    samples_checked++;
    if (out_a !== 8'h00) begin
      miscompares++;
      $display("MISMATCH %0t output latch kept over reset", $time);
    end
    acc('{iors_pkg::OP_IN_INSTR, 8'h02, 3'h0, 8'h00, 8'h00, 2'h0});
    req_valid = 1'b0;
    $display("Reset test done");
    complete_run();
  end
endmodule
